// ==== shared/lid_pkg.sv ====
// Purpose: Constants and types for the link instruction decoder
// Assumes: Framing and sum-code checking are done upstream
// Notes: Instruction codes are 8-bit values after hex decode
package lid_pkg;
  localparam logic [7:0] LID_RD_MODE = 8'h7b;
  localparam logic [7:0] LID_WR_MODE = 8'hfb;
  localparam logic [7:0] LID_RD_FREQ = 8'h6f;
  localparam logic [7:0] LID_RD_CURR = 8'h70;
  localparam logic [7:0] LID_RD_VOLT = 8'h71;
  localparam logic [7:0] LID_RD_SPEC = 8'h72;
  localparam logic [7:0] LID_RD_SSEL = 8'h73;
  localparam logic [7:0] LID_WR_SSEL = 8'hf3;
  localparam logic [7:0] LID_RD_HIST0 = 8'h74;
  localparam logic [7:0] LID_RD_HIST3 = 8'h77;
  localparam logic [7:0] LID_RD_STAT = 8'h79;
  localparam logic [7:0] LID_RD_STAT_B = 8'h7a;
  localparam logic [7:0] LID_WR_RUN = 8'hf9;
  localparam logic [7:0] LID_WR_RUN_B = 8'hfa;
  localparam logic [15:0] LID_MODE_NET = 16'h0000;
  localparam logic [15:0] LID_MODE_EXT = 16'h0001;
  localparam logic [15:0] LID_MODE_PANEL = 16'h0002;
  localparam logic [7:0] LID_FAULT_LINK = 8'h40;
  localparam logic [7:0] LID_SSEL_RESET = 8'h01;
  localparam logic [7:0] LID_MON_DUAL = 8'h64;
  localparam logic [2:0] LID_DIG_ERR = 3'h0;
  localparam logic [2:0] LID_DIG_2 = 3'h2;
  localparam logic [2:0] LID_DIG_4 = 3'h4;
  localparam logic [2:0] LID_DIG_6 = 3'h6;
  localparam int LID_RUN_FWD_BIT = 1;
  localparam int LID_RUN_REV_BIT = 2;
  localparam int LID_CLK_MHZ = 125;
  localparam int LID_CHECK_MS = 12;
  localparam int LID_CHECK_CYC = LID_CHECK_MS * 1000 * LID_CLK_MHZ;
  localparam int LID_MS_CYC = 1000 * LID_CLK_MHZ;
  localparam int LID_HIST_DEPTH = 8;
  typedef enum {LID_IDLE, LID_EXEC, LID_REPLY} lid_state_t;
endpackage : lid_pkg

// ==== verilog/lid_hist_mem.sv ====
// Purpose: Fault history store, newest first, read a word of two entries
// Assumes: One push per cycle at most
// Notes: Read data is registered, one cycle latency
`timescale 1ns/100ps
module lid_hist_mem
  import lid_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [7:0] code_i,
  input wire logic [1:0] rd_word_i,
  output logic [15:0] rd_data_o
);
  logic [7:0] ent_reg [LID_HIST_DEPTH];
  logic [7:0] ent_next [LID_HIST_DEPTH];
  logic [15:0] rd_reg;
  logic [15:0] rd_next;

  always_comb begin
    for (int i = 0; i < LID_HIST_DEPTH; i++) begin
      ent_next[i] = ent_reg[i];
    end
    if (push_i) begin
      ent_next[0] = code_i;
      for (int i = 1; i < LID_HIST_DEPTH; i++) begin
        ent_next[i] = ent_reg[i-1];
      end
    end
    // Older entry high byte, newer low byte
    rd_next = {ent_reg[{rd_word_i, 1'b1}], ent_reg[{rd_word_i, 1'b0}]};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < LID_HIST_DEPTH; i++) begin
        ent_reg[i] <= 8'h00;
      end
      rd_reg <= 16'h0000;
    end else begin
      ent_reg <= ent_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data_o = rd_reg;
endmodule : lid_hist_mem

// ==== verilog/lid_decoder.sv ====
// Contract
// - Only answer host requests, each exactly once, never send unprompted.
// - Check interval expiry forces alarm stop and logs link timeout fault.
// - Zero check interval disables link loss detection; state is kept.
// - Coast-stop input coasts the motor regardless of link state.
// - Mode codes 0 network, 1 external, 2 panel; readable, writable 4 digits.
// - Frequency read returns 16 bits in 0.01 Hz steps, 4 digits.
// - Scale in range plus extension 01 gives 0.001 steps, 6 digits.
// - Monitor select 100 makes frequency value differ stopped versus running.
// - Current read returns 16 bits in 0.01 A steps, 4 digits.
// - Voltage read returns 16 bits in 0.1 V steps, 4 digits.
// - Special monitor returns selected quantity; selection written, read, 2 digits.
// - Four history words, newer fault low byte, first word holds latest.
// - Run commands drive forward and reverse inputs, 4 or 2 digits.
// - Status read reports forward, reverse, running; 4 or 2 digits.
// - Frames with detected data errors are rejected and not acted on.
// - Characters are one start bit, 9 to 12 bits total.
// - Monitor reads and run commands checked well within 12 ms.
//
// Purpose: Decode link instructions, hold mode and run command, build replies
// Assumes: Upstream framer delivers checked frames with code and data words
// Notes: Reply is a pulse with a data word and a digit count; zero digits means error
`timescale 1ns/100ps
module lid_decoder
  import lid_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_err_i,
  input wire logic req_station_ok_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_data_i,
  input wire logic [15:0] check_ms_i,
  input wire logic coast_stop_input,
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] out_freq_fine_i,
  input wire logic [15:0] set_freq_i,
  input wire logic [15:0] out_curr_i,
  input wire logic [15:0] out_volt_i,
  input wire logic [15:0] spec_mon_i,
  input wire logic running_i,
  input wire logic scale_in_range_i,
  input wire logic [7:0] link_ext_i,
  input wire logic [7:0] monitor_select_param,
  input wire logic fault_push_i,
  input wire logic [7:0] fault_code_i,
  output logic reply_valid_o,
  output logic [23:0] reply_data_o,
  output logic [2:0] reply_digits_o,
  output logic [15:0] op_mode_o,
  output logic [7:0] spec_sel_o,
  output logic forward_rotation_cmd,
  output logic reverse_rotation_cmd,
  output logic coast_o,
  output logic alarm_stop_o,
  output logic link_timeout_fault
);
  // Two-stage synchroniser for the external coast pin
  logic coast_s1_reg;
  logic coast_s2_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      coast_s1_reg <= 1'b0;
      coast_s2_reg <= 1'b0;
    end else begin
      coast_s1_reg <= coast_stop_input;
      coast_s2_reg <= coast_s1_reg;
    end
  end

  function automatic logic is_read_only(input logic [7:0] code);
    is_read_only = (code == LID_RD_MODE) || (code == LID_RD_FREQ) || (code == LID_RD_CURR) ||
      (code == LID_RD_VOLT) || (code == LID_RD_SPEC) || (code == LID_RD_SSEL) ||
      (code >= LID_RD_HIST0 && code <= LID_RD_HIST3) || (code == LID_RD_STAT) ||
      (code == LID_RD_STAT_B);
  endfunction : is_read_only

  function automatic logic is_writable(input logic [7:0] code);
    is_writable = (code == LID_WR_MODE) || (code == LID_WR_SSEL) || (code == LID_WR_RUN) ||
      (code == LID_WR_RUN_B);
  endfunction : is_writable

  lid_state_t state_reg, state_next;
  logic [7:0] code_reg, code_next;
  logic wr_reg, wr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] mode_reg, mode_next;
  logic [7:0] ssel_reg, ssel_next;
  logic fwd_reg, fwd_next;
  logic rev_reg, rev_next;
  logic rv_reg, rv_next;
  logic [23:0] rd_reg, rd_next;
  logic [2:0] dig_reg, dig_next;
  logic [15:0] hist_word;
  logic [15:0] freq_word;
  logic fine_mode;

  // Check timer: counts milliseconds since the last good frame
  logic [16:0] ms_reg, ms_next;
  logic [16:0] tick_reg, tick_next;
  logic fault_reg, fault_next;
  logic timeout_hit;
  logic good_frame;

  lid_hist_mem u_hist (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .push_i(fault_push_i || (timeout_hit && !fault_reg)),
    .code_i((timeout_hit && !fault_reg) ? LID_FAULT_LINK : fault_code_i),
    .rd_word_i(code_reg[1:0]),
    .rd_data_o(hist_word)
  );

  // Character framing faults arrive on req_err_i, so a bad start bit or length drops the frame
  assign good_frame = req_valid_i && !req_err_i && req_station_ok_i;
  assign timeout_hit = (check_ms_i != 16'h0000) && (ms_reg[15:0] >= check_ms_i);

  always_comb begin
    tick_next = tick_reg;
    ms_next = ms_reg;
    fault_next = fault_reg || timeout_hit;
    if (good_frame) begin
      tick_next = 17'h00000;
      ms_next = 17'h00000;
    end else if (check_ms_i == 16'h0000) begin
      ms_next = 17'h00000;
    end else if (tick_reg == 17'(LID_MS_CYC - 1)) begin
      tick_next = 17'h00000;
      if (!timeout_hit) begin
        ms_next = ms_reg + 17'h00001;
      end
    end else begin
      tick_next = tick_reg + 17'h00001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_reg <= 17'h00000;
      ms_reg <= 17'h00000;
      fault_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      ms_reg <= ms_next;
      fault_reg <= fault_next;
    end
  end

  // Frequency selection; fine steps only with range and extension 01
  assign fine_mode = scale_in_range_i && (link_ext_i == 8'h01);
  always_comb begin
    freq_word = out_freq_i;
    if (monitor_select_param == LID_MON_DUAL && !running_i) begin
      freq_word = set_freq_i;
    end
  end

  // Command execution: one reply per accepted frame, three-cycle turnaround
  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    wr_next = wr_reg;
    wdata_next = wdata_reg;
    mode_next = mode_reg;
    ssel_next = ssel_reg;
    fwd_next = fwd_reg;
    rev_next = rev_reg;
    rv_next = 1'b0;
    rd_next = rd_reg;
    dig_next = dig_reg;
    unique case (state_reg)
      LID_IDLE: begin
        if (good_frame) begin
          code_next = req_code_i;
          wr_next = req_write_i;
          wdata_next = req_data_i;
          state_next = LID_EXEC;
        end
      end
      LID_EXEC: begin
        // Waits one cycle so the history read has settled
        state_next = LID_REPLY;
      end
      LID_REPLY: begin
        rv_next = 1'b1;
        rd_next = 24'h000000;
        dig_next = LID_DIG_4;
        if (wr_reg ? !is_writable(code_reg) : !is_read_only(code_reg)) begin
          dig_next = LID_DIG_ERR;
        end else if (wr_reg) begin
          dig_next = LID_DIG_ERR;
          unique case (code_reg)
            LID_WR_MODE: begin
              if (wdata_reg <= LID_MODE_PANEL) begin
                mode_next = wdata_reg;
                dig_next = LID_DIG_4;
              end
            end
            LID_WR_SSEL: begin
              ssel_next = wdata_reg[7:0];
              dig_next = LID_DIG_2;
            end
            LID_WR_RUN, LID_WR_RUN_B: begin
              fwd_next = wdata_reg[LID_RUN_FWD_BIT];
              rev_next = wdata_reg[LID_RUN_REV_BIT];
              dig_next = (code_reg == LID_WR_RUN) ? LID_DIG_4 : LID_DIG_2;
            end
            default: dig_next = LID_DIG_ERR;
          endcase
        end else begin
          if (code_reg == LID_RD_MODE) begin
            rd_next = {8'h00, mode_reg};
          end else if (code_reg == LID_RD_FREQ) begin
            if (fine_mode) begin
              rd_next = {8'h00, out_freq_fine_i};
              dig_next = LID_DIG_6;
            end else begin
              rd_next = {8'h00, freq_word};
            end
          end else if (code_reg == LID_RD_CURR) begin
            rd_next = {8'h00, out_curr_i};
          end else if (code_reg == LID_RD_VOLT) begin
            rd_next = {8'h00, out_volt_i};
          end else if (code_reg == LID_RD_SPEC) begin
            rd_next = {8'h00, spec_mon_i};
          end else if (code_reg == LID_RD_SSEL) begin
            rd_next = {16'h0000, ssel_reg};
            dig_next = LID_DIG_2;
          end else if (code_reg == LID_RD_STAT || code_reg == LID_RD_STAT_B) begin
            rd_next = {21'h000000, rev_reg, fwd_reg, running_i};
            dig_next = (code_reg == LID_RD_STAT) ? LID_DIG_4 : LID_DIG_2;
          end else begin
            rd_next = {8'h00, hist_word};
          end
        end
        state_next = LID_IDLE;
      end
    endcase
    // Timeout alarm drops the run command; the sticky fault keeps later run writes from restarting
    if (timeout_hit || fault_reg) begin
      fwd_next = 1'b0;
      rev_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= LID_IDLE;
      code_reg <= 8'h00;
      wr_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      mode_reg <= LID_MODE_EXT;
      ssel_reg <= LID_SSEL_RESET;
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= 24'h000000;
      dig_reg <= LID_DIG_ERR;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
      mode_reg <= mode_next;
      ssel_reg <= ssel_next;
      fwd_reg <= fwd_next;
      rev_reg <= rev_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      dig_reg <= dig_next;
    end
  end

  assign reply_valid_o = rv_reg;
  assign reply_data_o = rd_reg;
  assign reply_digits_o = dig_reg;
  assign op_mode_o = mode_reg;
  assign spec_sel_o = ssel_reg;
  assign forward_rotation_cmd = fwd_reg;
  assign reverse_rotation_cmd = rev_reg;
  assign coast_o = coast_s2_reg;
  assign alarm_stop_o = fault_reg;
  assign link_timeout_fault = fault_reg;
endmodule : lid_decoder

// ==== bench/lid_host_model.sv ====
// Purpose: Host side of the link, issues checked frames
// Assumes: Framing and sum code are handled upstream
// Notes: Waits at most 8 cycles for an answer
`timescale 1ns/100ps
module lid_host_model (
  input wire logic sys_clk_i,
  input wire logic reply_valid_o,
  input wire logic [23:0] reply_data_o,
  input wire logic [2:0] reply_digits_o,
  output logic req_valid_i,
  output logic req_err_i,
  output logic req_station_ok_i,
  output logic req_write_i,
  output logic [7:0] req_code_i,
  output logic [15:0] req_data_i
);
  initial begin
    {req_valid_i, req_err_i, req_station_ok_i, req_write_i, req_code_i, req_data_i} = '0;
  end

  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d, input logic e,
                      input logic s, output logic got, output logic [23:0] rd, output logic [2:0] dg);
    @(posedge sys_clk_i);
    #1;
    {req_valid_i, req_write_i, req_code_i} = {1'b1, w, c};
    {req_data_i, req_err_i, req_station_ok_i} = {d, e, s};
    @(posedge sys_clk_i);
    #1;
    // Released lines flip so a stale value cannot pass for held data
    {req_valid_i, req_code_i, req_data_i} = {1'b0, ~c, ~d};
    got = 1'b0;
    rd = '0;
    dg = '0;
    for (int n = 0; n < 8 && !got; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (reply_valid_o === 1'b1) begin
        got = 1'b1;
        rd = reply_data_o;
        dg = reply_digits_o;
      end
    end
  endtask : send
endmodule : lid_host_model

// ==== bench/lid_decoder_checker.sv ====
// Purpose: Port-level checks of the decoder
// Assumes: Reply comes three edges after the taking edge
// Notes: Bound into every decoder instance
`timescale 1ns/100ps
module lid_decoder_checker
  import lid_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_err_i,
  input wire logic req_station_ok_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_data_i,
  input wire logic [15:0] check_ms_i,
  input wire logic coast_stop_input,
  input wire logic reply_valid_o,
  input wire logic [2:0] reply_digits_o,
  input wire logic [15:0] op_mode_o,
  input wire logic forward_rotation_cmd,
  input wire logic reverse_rotation_cmd,
  input wire logic coast_o,
  input wire logic alarm_stop_o,
  input wire logic link_timeout_fault
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  reply_has_cause_a: assert property (reply_valid_o
    |-> $past(req_valid_i && !req_err_i && req_station_ok_i, 3))
    else $error("Reply without a request");
  request_answered_a: assert property (req_valid_i && !req_err_i && req_station_ok_i && !$past(req_valid_i)
    && !$past(req_valid_i, 2) |-> ##3 reply_valid_o) else $error("Request not answered");
  bad_frame_silent_a: assert property (req_valid_i && (req_err_i || !req_station_ok_i)
    |-> ##3 !reply_valid_o)
    else $error("Bad frame answered");
  timeout_sticky_a: assert property (link_timeout_fault |=> link_timeout_fault && alarm_stop_o)
    else $error("Timeout fault lost or no alarm stop");
  alarm_stops_run_a: assert property (alarm_stop_o |=> !forward_rotation_cmd && !reverse_rotation_cmd)
    else $error("Run command kept in alarm stop");
  no_check_quiet_a: assert property (check_ms_i == 16'h0000 |-> !$rose(link_timeout_fault))
    else $error("Timeout with check disabled");
  coast_follows_a: assert property (coast_stop_input [*3] |-> coast_o)
    else $error("Coast not applied");
  mode_write_a: assert property (reply_valid_o && $past(req_write_i && req_code_i == LID_WR_MODE
    && req_data_i <= 16'h0002, 3) |-> op_mode_o == $past(req_data_i, 3)) else $error("Mode write lost");
  bad_mode_kept_a: assert property (reply_valid_o && $past(req_write_i && req_code_i == LID_WR_MODE
    && req_data_i > 16'h0002, 3) |-> reply_digits_o == LID_DIG_ERR && $stable(op_mode_o))
    else $error("Bad mode accepted");
endmodule : lid_decoder_checker

bind lid_decoder lid_decoder_checker lid_chk_i (.*);

// ==== bench/link_instruction_decoder_bench.sv ====
// Purpose: Sequence of host requests with expected answers
// Assumes: Check interval zero until the timeout leg, then 1 ms; faults pushed by the bench
// Notes: Timeout leg alone takes about 126000 cycles
`timescale 1ns/100ps
module link_instruction_decoder_bench;
  import lid_pkg::*;
  localparam logic [15:0] F = 16'h1388, C = 16'h0a5b, V = 16'h0dc0, S = 16'h0fa0, M = 16'h4321, X = 16'h2710;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, coast_stop_input = 1'b0, running_i = 1'b0, scale_in_range_i = 1'b0;
  logic fault_push_i = 1'b0, got, reply_valid_o, forward_rotation_cmd, reverse_rotation_cmd, coast_o;
  logic alarm_stop_o, link_timeout_fault, req_valid_i, req_err_i, req_station_ok_i, req_write_i;
  logic [15:0] check_ms_i = 16'h0000, out_freq_i = F, out_curr_i = C, out_volt_i = V, set_freq_i = S;
  logic [15:0] spec_mon_i = M, out_freq_fine_i = X, op_mode_o, req_data_i;
  logic [7:0] link_ext_i = 8'h00, monitor_select_param = 8'h00, fault_code_i = 8'h00, spec_sel_o, req_code_i;
  logic [23:0] reply_data_o, rd;
  logic [2:0] reply_digits_o, dg;
  int mismatches = 0, samples_checked = 0;

  lid_decoder dut (.*);
  lid_host_model host (.*);

  always #4 sys_clk_i = ~sys_clk_i;

  // Wide enough for digit count plus reply word, so the digit field is never cut off
  task automatic chk(input logic [26:0] g, input logic [26:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    host.send(w, c, d, 1'b0, 1'b1, got, rd, dg);
    chk(got, 1'b1);
  endtask : xfer

  task automatic complete_run();
    $display("Checks %0d, errors %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Watchdog sized well past the timeout leg
  initial begin
    #1200000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk({op_mode_o, spec_sel_o}, {LID_MODE_EXT, LID_SSEL_RESET});
    chk({reply_valid_o, forward_rotation_cmd, reverse_rotation_cmd, alarm_stop_o, link_timeout_fault}, 0);
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, LID_WR_MODE, m[15:0]);
      xfer(1'b0, LID_RD_MODE, 16'h0000);
      chk({dg, rd}, {LID_DIG_4, 8'h00, m[15:0]});
    end
    xfer(1'b1, LID_WR_MODE, 16'h0003);
    chk({dg, op_mode_o}, {LID_DIG_ERR, LID_MODE_PANEL});
    xfer(1'b0, 8'h55, 16'h0000);
    chk(dg, LID_DIG_ERR);
    xfer(1'b1, LID_RD_FREQ, 16'h0000);
    chk(dg, LID_DIG_ERR);
    for (int e = 0; e < 2; e++) begin
      host.send(1'b1, LID_WR_MODE, 16'h0000, !e[0], !e[0], got, rd, dg);
      chk({got, op_mode_o}, {1'b0, LID_MODE_PANEL});
    end
    for (int k = 0; k < 3; k++) begin
      xfer(1'b0, LID_RD_FREQ + 8'(k), 16'h0000);
      chk({dg, rd}, {LID_DIG_4, 8'h00, k == 0 ? F : k == 1 ? C : V});
    end
    scale_in_range_i = 1'b1;
    link_ext_i = 8'h01;
    xfer(1'b0, LID_RD_FREQ, 16'h0000);
    chk({dg, rd}, {LID_DIG_6, 8'h00, X});
    scale_in_range_i = 1'b0;
    link_ext_i = 8'h00;
    monitor_select_param = LID_MON_DUAL;
    for (int r = 0; r < 2; r++) begin
      running_i = r[0];
      xfer(1'b0, LID_RD_FREQ, 16'h0000);
      chk(rd, {8'h00, r[0] ? F : S});
    end
    xfer(1'b1, LID_WR_SSEL, 16'h0005);
    chk(spec_sel_o, 8'h05);
    xfer(1'b0, LID_RD_SSEL, 16'h0000);
    chk({dg, rd}, {LID_DIG_2, 24'h000005});
    xfer(1'b0, LID_RD_SPEC, 16'h0000);
    chk(rd, {8'h00, M});
    // Push held high across the burst so the strobe is never set twice in one step
    fault_push_i = 1'b1;
    for (int k = 1; k < 9; k++) begin
      fault_code_i = 8'(k);
      @(posedge sys_clk_i);
      #1;
    end
    fault_push_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, LID_RD_HIST0 + 8'(k), 16'h0000);
      chk({dg, rd}, {LID_DIG_4, 8'h00, 8'(7 - 2 * k), 8'(8 - 2 * k)});
    end
    xfer(1'b1, LID_WR_RUN, 16'h0002);
    chk({forward_rotation_cmd, reverse_rotation_cmd}, 2'b10);
    xfer(1'b0, LID_RD_STAT, 16'h0000);
    chk({dg, rd}, {LID_DIG_4, 24'h000003});
    xfer(1'b1, LID_WR_RUN_B, 16'h0004);
    chk({forward_rotation_cmd, reverse_rotation_cmd}, 2'b01);
    xfer(1'b0, LID_RD_STAT_B, 16'h0000);
    chk({dg, rd}, {LID_DIG_2, 24'h000005});
    coast_stop_input = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(coast_o, 1'b1);
    coast_stop_input = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk({coast_o, link_timeout_fault}, 2'b00);
    xfer(1'b1, LID_WR_RUN, 16'h0002);
    check_ms_i = 16'h0001;
    xfer(1'b0, LID_RD_MODE, 16'h0000);
    repeat (124000) @(posedge sys_clk_i);
    #1;
    chk({link_timeout_fault, forward_rotation_cmd}, 2'b01);
    repeat (2000) @(posedge sys_clk_i);
    #1;
    chk({link_timeout_fault, alarm_stop_o, forward_rotation_cmd}, 3'b110);
    xfer(1'b0, LID_RD_HIST0, 16'h0000);
    chk(rd, {8'h00, 8'h08, LID_FAULT_LINK});
    complete_run();
  end
endmodule : link_instruction_decoder_bench
